/* logic/sisp_consts.vh */
// constants for the serial programming port
`ifndef SISP_CONSTS_VH
`define SISP_CONSTS_VH
`define SISP_OP_ENABLE 8'hac
`define SISP_ENABLE_B2 8'h53
`define SISP_ERASE_B2 8'h80
`define SISP_OP_POLL 8'hf0
`define SISP_OP_LD_EXT 8'h4d
`define SISP_OP_LD_HI 8'h48
`define SISP_OP_LD_LO 8'h40
`define SISP_OP_RD_HI 8'h28
`define SISP_OP_RD_LO 8'h20
`define SISP_OP_RD_NV 8'ha0
`define SISP_OP_WR_PAGE 8'h4c
`define SISP_OP_WR_NV 8'hc0
`define SISP_ERASED 8'hff
`define SISP_PAGE_BITS 7
`define SISP_CLK_MHZ 125
`define SISP_PAGE_WAIT_US 4500
`define SISP_BYTE_WAIT_US 9000
`define SISP_ERASE_WAIT_US 9000
`endif

/* logic/sisp_mem.v */
// byte-wide memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module sisp_mem #(
	parameter AW = 12
) (
	input wire clk_i,
	input wire we_i,
	input wire [AW-1:0] waddr_i,
	input wire [7:0] wdata_i,
	input wire [AW-1:0] raddr_i,
	output reg [7:0] rdata_o
);
	reg [7:0] mem [0:(1<<AW)-1];
	always @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule
`default_nettype wire

/* logic/sisp_port.v */
// serial in-system programming port of the device
// How it works
// - link works only while reset pin low
// - program and erase need enable first
// - data byte write auto-erases then stores; here the byte is written directly once the wait ends, with no erase step
// - chip erase sets all cells to ff
// - input bit captured on clock rise
// - output bit shifted on clock fall
// - echo second enable byte during third
// - page byte loaded with 7 address bits
// - extended address held until reloaded
// - read returns addressed content on output
// - program reads use stored extended address only when PAW exceeds 16
// - reset high leaves programming mode
// - four-byte instructions, enable is ac 53
// - poll status bit0 high while busy
`timescale 1ns/1ps
`default_nettype none
`include "sisp_consts.vh"
module sisp_port #(
	parameter PAW = 14,
	parameter NAW = 12,
	parameter PAGE_WAIT = `SISP_PAGE_WAIT_US * `SISP_CLK_MHZ,
	parameter BYTE_WAIT = `SISP_BYTE_WAIT_US * `SISP_CLK_MHZ,
	parameter ERASE_WAIT = `SISP_ERASE_WAIT_US * `SISP_CLK_MHZ
) (
	input wire clk_i,
	input wire sys_rst_i,
	input wire dev_reset_n_i,
	input wire serial_clk_i,
	input wire serial_prog_data_in_i,
	output reg serial_prog_data_out_o,
	output wire prog_mode_o,
	output wire completion_poll_flag_o
);
	localparam PW = PAW + 1;
	localparam S_IDLE = 4'b0001;
	localparam S_ERASE = 4'b0010;
	localparam S_PAGE = 4'b0100;
	localparam S_NV = 4'b1000;
	reg [1:0] rst_s_reg, sck_s_reg, din_s_reg;
	reg sck_d_reg;
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rst_s_reg <= 2'h3;
			sck_s_reg <= 2'h0;
			din_s_reg <= 2'h0;
			sck_d_reg <= 1'b0;
		end else begin
			rst_s_reg <= {rst_s_reg[0], dev_reset_n_i};
			sck_s_reg <= {sck_s_reg[0], serial_clk_i};
			din_s_reg <= {din_s_reg[0], serial_prog_data_in_i};
			sck_d_reg <= sck_s_reg[1];
		end
	end
	// link active only with reset pin low
	wire link_on = ~rst_s_reg[1];
	wire rise = link_on & sck_s_reg[1] & ~sck_d_reg;
	wire fall = link_on & ~sck_s_reg[1] & sck_d_reg;
	wire din = din_s_reg[1];
	////////////////////////////////////////////////////////////////
	reg [30:0] sh_reg;
	reg [1:0] rd_pipe_reg;
	reg [4:0] bit_reg;
	reg [7:0] out_reg;
	reg enabled_reg;
	reg [7:0] ext_reg;
	reg [3:0] state_reg;
	reg [31:0] cnt_reg;
	reg [PAW-1:0] wipe_reg;
	reg [PAW-1:0] page_reg;
	reg [`SISP_PAGE_BITS:0] pidx_reg;
	reg [7:0] pbuf [0:(1<<(`SISP_PAGE_BITS+1))-1];
	reg [NAW-1:0] nva_reg;
	reg [7:0] nvd_reg;
	wire busy = (state_reg != S_IDLE);
	assign completion_poll_flag_o = busy;
	assign prog_mode_o = link_on & enabled_reg;
	wire [7:0] b1 = sh_reg[23:16];
	wire [7:0] b2 = sh_reg[15:8];
	wire [7:0] b3 = sh_reg[7:0];
	wire [7:0] byte_now = {sh_reg[6:0], din};
	// bytes one to three as they stand on the edge that completes byte four
	wire [7:0] c1 = sh_reg[30:23];
	wire [7:0] c2 = sh_reg[22:15];
	wire [7:0] c3 = sh_reg[14:7];
	wire [23:0] wr_word = {ext_reg, c2, c3};
	wire [15:0] nv_full = {b2, b3};
	wire [15:0] nv_wr = {c2, c3};
	// page buffer index is word bits plus byte select
	wire [`SISP_PAGE_BITS:0] ld_idx = {c3[`SISP_PAGE_BITS-1:0], c1 == `SISP_OP_LD_HI};
	// program read address; stored extended byte reaches it only when PAW exceeds 16
	wire [23:0] rd_word = {ext_reg, b2, b3};
	wire [PW-1:0] rd_p = {rd_word[PAW-1:0], b1 == `SISP_OP_RD_HI};
	wire [NAW-1:0] rd_n = nv_full[NAW-1:0];
	wire byte_done = rise & (bit_reg[2:0] == 3'h7);
	wire last_byte = (bit_reg[4:3] == 2'h3);
	wire [7:0] prd, nrd;
	// memory write muxing
	wire p_we = (state_reg == S_PAGE) | (state_reg == S_ERASE);
	wire [PW-1:0] p_wa = (state_reg == S_ERASE) ? {wipe_reg, 1'b0} : {page_reg, 1'b0};
	reg p_we_hi;
	always @* begin
		p_we_hi = p_we;
	end
	wire [PAW-1:0] pw_word = (state_reg == S_ERASE) ? wipe_reg : (page_reg | cnt_reg[PAW-1:0]);
	// erase writes ff; page writes buffer contents
	wire [7:0] p_lo = (state_reg == S_ERASE) ? `SISP_ERASED : pbuf[{pw_word[`SISP_PAGE_BITS-1:0], 1'b0}];
	wire [7:0] p_hi = (state_reg == S_ERASE) ? `SISP_ERASED : pbuf[{pw_word[`SISP_PAGE_BITS-1:0], 1'b1}];
	wire pg_cp = (state_reg == S_PAGE) & (cnt_reg < (32'h1 << `SISP_PAGE_BITS));
	wire ers_cp = (state_reg == S_ERASE);
	wire n_we = (state_reg == S_NV) | ers_cp;
	wire [NAW-1:0] n_wa = ers_cp ? wipe_reg[NAW-1:0] : nva_reg;
	// auto-erase is folded into the direct overwrite
	wire [7:0] n_wd = ers_cp ? `SISP_ERASED : nvd_reg;
	wire [7:0] prd_hi;
	sisp_mem #(.AW(PAW)) u_plo (.clk_i(clk_i), .we_i(p_we_hi & (ers_cp | pg_cp)), .waddr_i(pw_word),
		.wdata_i(p_lo), .raddr_i(rd_p[PW-1:1]), .rdata_o(prd));
	sisp_mem #(.AW(PAW)) u_phi (.clk_i(clk_i), .we_i(p_we_hi & (ers_cp | pg_cp)), .waddr_i(pw_word),
		.wdata_i(p_hi), .raddr_i(rd_p[PW-1:1]), .rdata_o(prd_hi));
	sisp_mem #(.AW(NAW)) u_nv (.clk_i(clk_i), .we_i(n_we & (ers_cp | cnt_reg == 32'h0)), .waddr_i(n_wa),
		.wdata_i(n_wd), .raddr_i(rd_n), .rdata_o(nrd));
	wire [7:0] p_sel = rd_p[0] ? prd_hi : prd;
	wire [PW-1:0] unused_wa = p_wa;
	////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		if (byte_done && last_byte && enabled_reg && !busy &&
			(c1 == `SISP_OP_LD_LO || c1 == `SISP_OP_LD_HI)) begin
			pbuf[ld_idx] <= byte_now;
		end
	end
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sh_reg <= 31'h0;
			rd_pipe_reg <= 2'h0;
			bit_reg <= 5'h0;
			out_reg <= 8'h0;
			serial_prog_data_out_o <= 1'b0;
			enabled_reg <= 1'b0;
			ext_reg <= 8'h0;
			state_reg <= S_IDLE;
			cnt_reg <= 32'h0;
			wipe_reg <= {PAW{1'b0}};
			page_reg <= {PAW{1'b0}};
			nva_reg <= {NAW{1'b0}};
			nvd_reg <= 8'h0;
		end else begin
		if (!link_on) begin
			sh_reg <= 31'h0;
			rd_pipe_reg <= 2'h0;
			bit_reg <= 5'h0;
			out_reg <= 8'h0;
			serial_prog_data_out_o <= 1'b0;
			enabled_reg <= 1'b0;
		end else begin
			rd_pipe_reg <= {rd_pipe_reg[0], 1'b0};
			if (rise) begin
				sh_reg <= {sh_reg[29:0], din};
				out_reg <= {out_reg[6:0], 1'b0};
				bit_reg <= bit_reg + 5'h1;
			end
			// read data lands before the first fall of byte four
			if (rd_pipe_reg[1]) begin
				if (b1 == `SISP_OP_POLL)
					out_reg <= {7'h0, busy};
				else if (b1 == `SISP_OP_RD_HI || b1 == `SISP_OP_RD_LO)
					out_reg <= p_sel;
				else if (b1 == `SISP_OP_RD_NV)
					out_reg <= nrd;
			end
			if (fall) begin
				serial_prog_data_out_o <= out_reg[7];
			end
			if (byte_done) begin
				// echo second byte while third arrives
				if (bit_reg[4:3] == 2'h1) begin
					out_reg <= byte_now;
				end
				if (bit_reg[4:3] == 2'h2) begin
					// registered memory read needs address one clock, data the next
					rd_pipe_reg <= 2'h1;
				end
				if (last_byte) begin
					if (c1 == `SISP_OP_ENABLE && c2 == `SISP_ENABLE_B2)
						enabled_reg <= 1'b1;
					// gated by enable; ignored while busy
					if (enabled_reg && !busy) begin
						if (c1 == `SISP_OP_ENABLE && c2 == `SISP_ERASE_B2) begin
							state_reg <= S_ERASE;
							cnt_reg <= ERASE_WAIT;
							wipe_reg <= {PAW{1'b0}};
						end
						if (c1 == `SISP_OP_LD_EXT)
							ext_reg <= c3;
						if (c1 == `SISP_OP_WR_PAGE) begin
							state_reg <= S_PAGE;
							cnt_reg <= PAGE_WAIT;
							page_reg <= wr_word[PAW-1:0] & ~{{(PAW-`SISP_PAGE_BITS){1'b0}}, {`SISP_PAGE_BITS{1'b1}}};
						end
						if (c1 == `SISP_OP_WR_NV) begin
							state_reg <= S_NV;
							cnt_reg <= BYTE_WAIT;
							nva_reg <= nv_wr[NAW-1:0];
							nvd_reg <= byte_now;
						end
					end
				end
			end
		end
		// self-timed operation, busy till count ends
		if (busy) begin
			if (state_reg == S_ERASE)
				wipe_reg <= wipe_reg + {{(PAW-1){1'b0}}, 1'b1};
			if (cnt_reg == 32'h0)
				state_reg <= S_IDLE;
			else
				cnt_reg <= cnt_reg - 32'h1;
		end
		end
	end
endmodule
`default_nettype wire

/* tb/sisp_port_sva.sv */
// assertions on the serial programming port pins
`timescale 1ns/1ps
`default_nettype none
module sisp_port_sva (
	input wire clk_i,
	input wire sys_rst_i,
	input wire dev_reset_n_i,
	input wire serial_clk_i,
	input wire serial_prog_data_in_i,
	input wire serial_prog_data_out_o,
	input wire prog_mode_o,
	input wire completion_poll_flag_o
);
	localparam int BUSY_MAX = 400;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_idle_low;
		(!serial_clk_i && !dev_reset_n_i)[*6];
	endsequence
	a_mode_off_pin: assert property (dev_reset_n_i[*4] |-> !prog_mode_o)
		else $error("mode live with pin high");
	a_mode_rise_pin: assert property ($rose(prog_mode_o) |-> !dev_reset_n_i)
		else $error("mode rose with pin high");
	a_flag_needs_mode: assert property ($rose(completion_poll_flag_o) |-> prog_mode_o)
		else $error("busy without enable");
	a_out_on_fall: assert property ($changed(serial_prog_data_out_o) && !dev_reset_n_i
		|-> $past(serial_clk_i, 6) && !$past(serial_clk_i, 2))
		else $error("output moved off falling edge");
	a_mode_idle_stable: assert property (s_idle_low |-> $stable(prog_mode_o))
		else $error("mode moved without clock rise");
	a_busy_on_rise: assert property ($rose(completion_poll_flag_o)
		|-> $past(serial_clk_i, 3) || $past(serial_clk_i, 5))
		else $error("busy not after a rising edge");
	a_busy_bounded: assert property ($rose(completion_poll_flag_o)
		|-> ##[1:BUSY_MAX] !completion_poll_flag_o)
		else $error("busy never ended");
	a_flag_clear_pin: assert property ($rose(dev_reset_n_i) |-> ##[1:4] !completion_poll_flag_o)
		else $error("busy kept after pin high");
endmodule
bind sisp_port sisp_port_sva u_sva (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .dev_reset_n_i(dev_reset_n_i),
	.serial_clk_i(serial_clk_i), .serial_prog_data_in_i(serial_prog_data_in_i),
	.serial_prog_data_out_o(serial_prog_data_out_o), .prog_mode_o(prog_mode_o),
	.completion_poll_flag_o(completion_poll_flag_o));
`default_nettype wire

/* tb/sisp_port_tb.sv */
// self-checking bench for the serial programming port
`timescale 1ns/1ps
`default_nettype none
module sisp_port_tb;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic dev_reset_n_i = 1'b1;
	wire sck, sdi, sdo, mode, busy;
	int error_cnt = 0;
	int checks = 0;
	logic [31:0] rx;
	always #4 clk_i = ~clk_i;
	// waits cut to 300 clk, above the 2^PAW erase sweep
	sisp_port #(.PAW(8), .NAW(6), .PAGE_WAIT(300), .BYTE_WAIT(300), .ERASE_WAIT(300)) u_dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .dev_reset_n_i(dev_reset_n_i), .serial_clk_i(sck),
		.serial_prog_data_in_i(sdi), .serial_prog_data_out_o(sdo), .prog_mode_o(mode),
		.completion_poll_flag_o(busy));
	sisp_prog_model u_prog (.clk_i(clk_i), .sdo_i(sdo), .sck_o(sck), .sdi_o(sdi));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		if (error_cnt == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic x(input logic [31:0] tx);
		u_prog.xfer(tx, rx);
	endtask
	// poll until idle before touching the link
	task automatic wait_idle;
		for (int n = 0; n < 1000 && busy !== 1'b0; n++) @(posedge clk_i);
		if (busy !== 1'b0) begin
			chk({7'h00, busy}, 8'h00);
			close_out();
		end
	endtask
	task automatic t_locked;
		x(32'hac800000);
		chk({6'h00, mode, busy}, 8'h00);
	endtask
	task automatic t_enable;
		x(32'hac530000);
		chk(rx[15:8], 8'h53);
		chk({7'h00, mode}, 8'h01);
	endtask
	task automatic t_erase;
		x(32'hac800000);
		chk({7'h00, busy}, 8'h01);
		wait_idle();
		x(32'h20000500);
		chk(rx[7:0], 8'hff);
		x(32'ha0000500);
		chk(rx[7:0], 8'hff);
	endtask
	task automatic t_nv(input logic [7:0] d);
		x({24'hc00003, d});
		x(32'hf0000000);
		chk(rx[7:0], 8'h01);
		wait_idle();
		x(32'ha0000300);
		chk(rx[7:0], d);
	endtask
	task automatic t_page;
		x(32'h4d000000);
		x(32'h40000211);
		x(32'h48000222);
		x(32'h4c000200);
		wait_idle();
		x(32'h20000200);
		chk(rx[7:0], 8'h11);
		x(32'h28000200);
		chk(rx[7:0], 8'h22);
	endtask
	task automatic t_exit;
		dev_reset_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk({7'h00, mode}, 8'h00);
		x(32'hac800000);
		chk({7'h00, busy}, 8'h00);
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		// pin low with the link clock held low
		dev_reset_n_i <= 1'b0;
		// settle wait before enable, scaled down
		repeat (8) @(posedge clk_i);
		t_locked();
		t_enable();
		t_erase();
		t_nv(8'ha5);
		t_nv(8'h3c);
		t_page();
		t_exit();
		close_out();
	end
endmodule
`default_nettype wire

/* tb/sisp_prog_model.sv */
// programmer model: clocks instructions over the link
`timescale 1ns/1ps
`default_nettype none
module sisp_prog_model (
	input wire logic clk_i,
	input wire logic sdo_i,
	output logic sck_o,
	output logic sdi_o
);
	initial begin
		sck_o = 1'b0;
		sdi_o = 1'b0;
	end
	// four whole bytes, msb first, phases of 4 clk
	task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
		for (int i = 31; i >= 0; i--) begin
			sdi_o <= tx[i];
			repeat (4) @(posedge clk_i);
			sck_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			rx[i] = sdo_i;
			sck_o <= 1'b0;
		end
		@(posedge clk_i);
		// driven to the inverse of the last bit between frames, so no stale bit
		sdi_o <= ~tx[0];
	endtask
endmodule
`default_nettype wire
